//--- logic/hw_cursor_overlay_map.vh
// register map, field positions, reset values and codes of the cursor overlay register bank
`ifndef HW_CURSOR_OVERLAY_MAP_VH
`define HW_CURSOR_OVERLAY_MAP_VH

// byte addresses on the register bus (12-bit window)
`define OVL_ADDR_W 12
`define OVL_BITMAP_BASE 12'h800
`define OVL_BITMAP_LAST 12'hbfc
`define OVL_CONTROL_ADDR 12'hc00
`define OVL_CONFIG_ADDR 12'hc04
`define OVL_COLOUR_A_ADDR 12'hc08
`define OVL_COLOUR_B_ADDR 12'hc0c
`define OVL_POSITION_ADDR 12'hc10
`define OVL_TRIM_ADDR 12'hc14
`define OVL_MASK_ADDR 12'hc20
`define OVL_ACK_ADDR 12'hc24
`define OVL_RAW_ADDR 12'hc28
`define OVL_MASKED_ADDR 12'hc2c

// bitmap memory geometry
`define OVL_BITMAP_WORDS 256
`define OVL_SMALL_LAST_WORD 8'h3f
`define OVL_LARGE_LAST_WORD 8'hff

// field positions
`define OVL_VISIBLE_BIT 0
`define OVL_SELECT_MSB 5
`define OVL_SELECT_LSB 4
`define OVL_LARGE_BIT 0
`define OVL_SYNC_BIT 1
`define OVL_VORIGIN_MSB 25
`define OVL_VORIGIN_LSB 16
`define OVL_HORIGIN_MSB 9
`define OVL_HORIGIN_LSB 0
`define OVL_VTRIM_MSB 13
`define OVL_VTRIM_LSB 8
`define OVL_HTRIM_MSB 5
`define OVL_HTRIM_LSB 0
`define OVL_IRQ_BIT 0

// reset values
`define OVL_RESET_SELECT 2'h0
`define OVL_RESET_COORD 10'h000
`define OVL_RESET_TRIM 6'h00
`define OVL_RESET_COLOUR 24'h000000

// panel modes
`define OVL_PANEL_MONO_STN 2'h0
`define OVL_PANEL_COLOUR_STN 2'h1
`define OVL_PANEL_TFT24 2'h2

// pixel code assignment
`define OVL_CODE_COLOUR_A 2'h0
`define OVL_CODE_COLOUR_B 2'h1
`define OVL_CODE_TRANSPARENT 2'h2
`define OVL_CODE_INVERT 2'h3

// bus responses
`define OVL_RESP_OKAY 2'h0
`define OVL_RESP_SLVERR 2'h2

`endif

//--- logic/hw_cursor_overlay_regs.v
// cursor overlay register bank: axi4-lite slave, bitmap memory, shadows, interrupt status
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "hw_cursor_overlay_map.vh"

module hw_cursor_overlay_regs (
    input wire core_clk,
    input wire sys_rst,
    // axi4-lite slave
    input wire [`OVL_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`OVL_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // timing and panel state from the controller core (same clock)
    input wire vblank,
    input wire [1:0] panel_mode,
    // scan side
    input wire scan_rd_en,
    input wire [7:0] scan_word,
    input wire [1:0] scan_pixel_code,
    output reg [31:0] scan_rd_data,
    output reg overlay_visible,
    output reg large_image_select,
    output reg [9:0] horizontal_origin,
    output reg [9:0] vertical_origin,
    output reg [5:0] horizontal_trim,
    output reg [5:0] vertical_trim,
    output reg [23:0] pixel_colour,
    output reg pixel_transparent,
    output reg pixel_invert,
    output reg overlay_irq
);

    // byte-strobe merge used by the bitmap and every writable register except mask and ack
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // colour significance per panel type
    function [23:0] panel_colour;
        input [23:0] c;
        input [1:0] mode;
        begin
            case (mode)
                `OVL_PANEL_MONO_STN: panel_colour = {16'h0000, c[7:4], 4'h0};
                `OVL_PANEL_COLOUR_STN: panel_colour = c & 24'hf0f0f0;
                default: panel_colour = c;
            endcase
        end
    endfunction

    // true for any word address inside the bitmap window
    function is_bitmap;
        input [`OVL_ADDR_W-1:0] a;
        begin
            is_bitmap = (a >= `OVL_BITMAP_BASE) && (a <= `OVL_BITMAP_LAST);
        end
    endfunction

    // bitmap memory
    reg [31:0] bitmap [0:`OVL_BITMAP_WORDS-1];

    // programmed registers: the software-visible copies
    // the scan side takes select, origin and trim from the shadows, but reads the colours directly from these
    reg [1:0] image_select;
    reg blanking_update_mode;
    reg [23:0] overlay_colour_a;
    reg [23:0] overlay_colour_b;
    reg [9:0] prog_horizontal;
    reg [9:0] prog_vertical;
    reg [5:0] prog_htrim;
    reg [5:0] prog_vtrim;
    reg overlay_irq_enable;
    reg overlay_irq_raw;
    reg position_after_trim;
    reg [1:0] shadow_select;

    // write channel state
    reg aw_held;
    reg w_held;
    reg [`OVL_ADDR_W-1:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;

    // a write is applied once both halves are held and the last response has gone;
    // holding them in flops lets the master offer address and data in either order
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = do_write && (wr_addr == `OVL_CONTROL_ADDR);
    wire wr_cfg = do_write && (wr_addr == `OVL_CONFIG_ADDR);
    wire wr_col_a = do_write && (wr_addr == `OVL_COLOUR_A_ADDR);
    wire wr_col_b = do_write && (wr_addr == `OVL_COLOUR_B_ADDR);
    wire wr_pos = do_write && (wr_addr == `OVL_POSITION_ADDR);
    wire wr_trim = do_write && (wr_addr == `OVL_TRIM_ADDR);
    wire wr_mask = do_write && (wr_addr == `OVL_MASK_ADDR);
    wire wr_ack = do_write && (wr_addr == `OVL_ACK_ADDR);
    wire wr_map = is_bitmap(wr_addr) || wr_ctrl || wr_cfg || wr_col_a || wr_col_b ||
        wr_pos || wr_trim || wr_mask || wr_ack ||
        (wr_addr == `OVL_RAW_ADDR) || (wr_addr == `OVL_MASKED_ADDR);

    wire [31:0] ctrl_word = {26'h0, image_select, 3'h0, overlay_visible};
    wire [31:0] cfg_word = {30'h0, blanking_update_mode, large_image_select};
    wire [31:0] pos_word = {6'h0, prog_vertical, 6'h0, prog_horizontal};
    wire [31:0] trim_word = {18'h0, prog_vtrim, 2'h0, prog_htrim};
    wire [31:0] ctrl_new = merge(ctrl_word, wr_data, wr_strb);
    wire [31:0] cfg_new = merge(cfg_word, wr_data, wr_strb);
    wire [31:0] pos_new = merge(pos_word, wr_data, wr_strb);
    wire [31:0] trim_new = merge(trim_word, wr_data, wr_strb);
    wire [31:0] col_a_new = merge({8'h00, overlay_colour_a}, wr_data, wr_strb);
    wire [31:0] col_b_new = merge({8'h00, overlay_colour_b}, wr_data, wr_strb);

    // write address and data are taken independently, then applied together
    always @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OVL_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= {`OVL_ADDR_W{1'b0}};
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr <= {s_axi_awaddr[`OVL_ADDR_W-1:2], 2'b00};
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `OVL_RESP_OKAY : `OVL_RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            // a new write is only accepted once the response has gone
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // bitmap memory writes; no reset so it maps onto a plain ram
    always @(posedge core_clk) begin
        if (do_write && is_bitmap(wr_addr)) begin
            bitmap[wr_addr[9:2]] <= merge(bitmap[wr_addr[9:2]], wr_data, wr_strb);
        end
    end

    // programmed control, configuration, colour, position and trim registers
    always @(posedge core_clk) begin
        if (sys_rst) begin
            overlay_visible <= 1'b0;
            image_select <= `OVL_RESET_SELECT;
            large_image_select <= 1'b0;
            blanking_update_mode <= 1'b0;
            overlay_colour_a <= `OVL_RESET_COLOUR;
            overlay_colour_b <= `OVL_RESET_COLOUR;
            prog_horizontal <= `OVL_RESET_COORD;
            prog_vertical <= `OVL_RESET_COORD;
            prog_htrim <= `OVL_RESET_TRIM;
            prog_vtrim <= `OVL_RESET_TRIM;
            overlay_irq_enable <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                overlay_visible <= ctrl_new[`OVL_VISIBLE_BIT];
                image_select <= ctrl_new[`OVL_SELECT_MSB:`OVL_SELECT_LSB];
            end
            if (wr_cfg) begin
                large_image_select <= cfg_new[`OVL_LARGE_BIT];
                blanking_update_mode <= cfg_new[`OVL_SYNC_BIT];
            end
            if (wr_col_a) begin
                overlay_colour_a <= col_a_new[23:0];
            end
            if (wr_col_b) begin
                overlay_colour_b <= col_b_new[23:0];
            end
            // expansion bits are not stored, so they read back as zero
            if (wr_pos) begin
                prog_vertical <= pos_new[`OVL_VORIGIN_MSB:`OVL_VORIGIN_LSB];
                prog_horizontal <= pos_new[`OVL_HORIGIN_MSB:`OVL_HORIGIN_LSB];
            end
            if (wr_trim) begin
                prog_vtrim <= trim_new[`OVL_VTRIM_MSB:`OVL_VTRIM_LSB];
                prog_htrim <= trim_new[`OVL_HTRIM_MSB:`OVL_HTRIM_LSB];
            end
            if (wr_mask) begin
                overlay_irq_enable <= wr_strb[0] ? wr_data[`OVL_IRQ_BIT] : overlay_irq_enable;
            end
        end
    end

    // shadows feed the scan logic; in blanking mode they only move during vblank
    // trim waits for a position write after it, so a frame never sees half a move
    // leaving blanking mode lets every shadow catch up on the next edge
    always @(posedge core_clk) begin
        if (sys_rst) begin
            shadow_select <= `OVL_RESET_SELECT;
            horizontal_origin <= `OVL_RESET_COORD;
            vertical_origin <= `OVL_RESET_COORD;
            horizontal_trim <= `OVL_RESET_TRIM;
            vertical_trim <= `OVL_RESET_TRIM;
            position_after_trim <= 1'b0;
        end else if (!blanking_update_mode) begin
            shadow_select <= image_select;
            horizontal_origin <= prog_horizontal;
            vertical_origin <= prog_vertical;
            horizontal_trim <= prog_htrim;
            vertical_trim <= prog_vtrim;
            position_after_trim <= 1'b0;
        end else begin
            if (vblank) begin
                shadow_select <= image_select;
                horizontal_origin <= prog_horizontal;
                vertical_origin <= prog_vertical;
            end
            if (vblank && position_after_trim) begin
                horizontal_trim <= prog_htrim;
                vertical_trim <= prog_vtrim;
            end
            // pending flag: set by a position write, dropped by a trim write or a load
            if (wr_pos) begin
                position_after_trim <= 1'b1;
            end else if (wr_trim || vblank) begin
                position_after_trim <= 1'b0;
            end
        end
    end

    // image base: quarter of the memory in small size, whole memory in large size
    wire [7:0] scan_addr = large_image_select ? scan_word :
        {shadow_select, scan_word[5:0]};
    wire [7:0] last_word = large_image_select ? `OVL_LARGE_LAST_WORD : `OVL_SMALL_LAST_WORD;
    // the final word of the active image raises status whatever the trim says;
    // the scan side fetches the whole image even when trimmed, so it comes once a frame
    wire last_read = scan_rd_en && (scan_word == last_word);

    // scan read port and pixel decode, one cycle of latency each
    always @(posedge core_clk) begin
        if (sys_rst) begin
            scan_rd_data <= 32'h00000000;
            pixel_colour <= `OVL_RESET_COLOUR;
            pixel_transparent <= 1'b1;
            pixel_invert <= 1'b0;
        end else begin
            if (scan_rd_en) begin
                scan_rd_data <= bitmap[scan_addr];
            end
            pixel_colour <= 24'h000000;
            pixel_transparent <= 1'b0;
            pixel_invert <= 1'b0;
            case (scan_pixel_code)
                `OVL_CODE_COLOUR_A: begin
                    pixel_colour <= panel_colour(overlay_colour_a, panel_mode);
                end
                `OVL_CODE_COLOUR_B: begin
                    pixel_colour <= panel_colour(overlay_colour_b, panel_mode);
                end
                `OVL_CODE_TRANSPARENT: pixel_transparent <= 1'b1;
                default: pixel_invert <= 1'b1;
            endcase
        end
    end

    // raw status: a set in the same cycle as an ack wins, so no event is lost
    wire ack_hit = wr_ack && wr_strb[0] && wr_data[`OVL_IRQ_BIT];
    wire next_raw = last_read | (overlay_irq_raw & ~ack_hit);
    wire next_mask = wr_mask ? (wr_strb[0] ? wr_data[`OVL_IRQ_BIT] : overlay_irq_enable) :
        overlay_irq_enable;
    // the output is built from next values so it never lags the masked register by a cycle

    always @(posedge core_clk) begin
        if (sys_rst) begin
            overlay_irq_raw <= 1'b0;
            overlay_irq <= 1'b0;
        end else begin
            overlay_irq_raw <= next_raw;
            overlay_irq <= next_raw & next_mask;
        end
    end

    // read address with the byte offset dropped, so an unaligned address hits its word
    wire [`OVL_ADDR_W-1:0] rd_addr = {s_axi_araddr[`OVL_ADDR_W-1:2], 2'b00};

    // read channel: data returned the cycle after the address is taken
    always @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `OVL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `OVL_RESP_OKAY;
            if (is_bitmap(rd_addr)) begin
                s_axi_rdata <= bitmap[rd_addr[9:2]];
            end else begin
                case (rd_addr)
                    `OVL_CONTROL_ADDR: s_axi_rdata <= ctrl_word;
                    `OVL_CONFIG_ADDR: s_axi_rdata <= cfg_word;
                    `OVL_COLOUR_A_ADDR: s_axi_rdata <= {8'h00, overlay_colour_a};
                    `OVL_COLOUR_B_ADDR: s_axi_rdata <= {8'h00, overlay_colour_b};
                    `OVL_POSITION_ADDR: s_axi_rdata <= pos_word;
                    `OVL_TRIM_ADDR: s_axi_rdata <= trim_word;
                    `OVL_MASK_ADDR: s_axi_rdata <= {31'h0, overlay_irq_enable};
                    `OVL_ACK_ADDR: s_axi_rdata <= 32'h00000000; // write-only
                    `OVL_RAW_ADDR: s_axi_rdata <= {31'h0, overlay_irq_raw};
                    `OVL_MASKED_ADDR: begin
                        s_axi_rdata <= {31'h0, overlay_irq_raw & overlay_irq_enable};
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `OVL_RESP_SLVERR;
                    end
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // hw_cursor_overlay_regs
`default_nettype wire

//--- dv/hw_cursor_overlay_checker.sv
// port-level assertions for the cursor overlay register bank
`timescale 1ns/1ps
`default_nettype none
module hw_cursor_overlay_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scan_rd_en,
    input wire logic [1:0] scan_pixel_code,
    input wire logic [1:0] panel_mode,
    input wire logic [23:0] pixel_colour,
    input wire logic pixel_transparent,
    input wire logic pixel_invert,
    input wire logic overlay_irq
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // bus answers come at the documented distance and are not repeated
    chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");

    // pixel decode one cycle after the code
    chk_code_transparent: assert property (
        scan_pixel_code == 2'h2 |=> pixel_transparent && !pixel_invert && pixel_colour == 24'h0)
        else $error("transparent code misdecoded");
    chk_code_invert: assert property (
        scan_pixel_code == 2'h3 |=> pixel_invert && !pixel_transparent)
        else $error("invert code misdecoded");
    // the release edge is left out: the decode still shows its reset state after it
    chk_code_colour: assert property (
        !sys_rst && scan_pixel_code[1] == 1'b0 |=> !pixel_invert && !pixel_transparent)
        else $error("colour code misdecoded");

    // panels with fewer colour bits only see the upper nibbles
    chk_mono_nibble: assert property (
        panel_mode == 2'h0 |=> pixel_colour[23:8] == 16'h0 && pixel_colour[3:0] == 4'h0)
        else $error("mono colour not reduced");
    chk_stn_nibbles: assert property (
        panel_mode == 2'h1 |=> (pixel_colour & 24'h0f0f0f) == 24'h0)
        else $error("stn colour not reduced");

    // the interrupt only rises after a scan read or a register write
    chk_irq_origin: assert property (
        $rose(overlay_irq) |-> s_axi_bvalid || $past(scan_rd_en) || $past(scan_rd_en, 2)
        || $past(scan_rd_en, 3)) else $error("interrupt without cause");
endmodule // hw_cursor_overlay_checker

bind hw_cursor_overlay_regs hw_cursor_overlay_checker i_hw_cursor_overlay_checker (.*);
`default_nettype wire

//--- dv/test_hw_cursor_overlay_regs.sv
// self-checking bench for the cursor overlay register bank
`timescale 1ns/1ps
`default_nettype none
`include "hw_cursor_overlay_map.vh"
module test_hw_cursor_overlay_regs;
    logic core_clk, sys_rst, vblank, scan_rd_en, s_axi_bready, s_axi_rready;
    logic [`OVL_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, overlay_visible, large_image_select;
    logic [31:0] s_axi_wdata, s_axi_rdata, scan_rd_data, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, panel_mode, scan_pixel_code, rs;
    logic pixel_transparent, pixel_invert, overlay_irq;
    logic [7:0] scan_word;
    logic [9:0] horizontal_origin, vertical_origin;
    logic [5:0] horizontal_trim, vertical_trim;
    logic [23:0] pixel_colour;
    logic [31:0] exp_pix [4] = '{32'h0012ab56, 32'h00abcdef, 32'h01000000, 32'h02000000};
    logic [7:0] words [5] = '{8'h05, 8'h80, 8'h85, 8'hc0, 8'hff};
    int errors, compares;

    hw_cursor_overlay_regs i_hw_cursor_overlay_regs (.*);

    // 200 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    // let n edges pass and step clear of them before looking at outputs
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // one write; address and data offered together, each released once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        rs = s_axi_bresp;
        if (n >= 40) begin
            errors++;
            $display("unexpected at %0t ns: no write response", $time);
        end
    endtask

    // one read; ready stays high so data is taken at the first valid edge
    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        if (n >= 40) begin
            errors++;
            $display("unexpected at %0t ns: no read data", $time);
        end
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        chk(rv, exp);
    endtask

    // one scan word fetch as the overlay logic would make it
    task automatic scan(input logic [7:0] w);
        @(posedge core_clk);
        scan_rd_en <= 1'b1;
        scan_word <= w;
        @(posedge core_clk);
        scan_rd_en <= 1'b0;
        tick(1);
    endtask

    // a short vertical blanking period
    task automatic blank();
        @(posedge core_clk);
        vblank <= 1'b1;
        repeat (2) @(posedge core_clk);
        vblank <= 1'b0;
        tick(2);
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // cut a hang short well beyond the expected microsecond or so
    initial begin
        #50000;
        errors++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        conclude();
    end

    // main sequence
    initial begin
        errors = 0;
        compares = 0;
        {sys_rst, s_axi_bready, s_axi_rready} = 3'h7;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, vblank, scan_rd_en} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hf;
        panel_mode = `OVL_PANEL_TFT24;
        scan_pixel_code = 2'h0;
        scan_word = 8'h00;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        // reset values stand until the first edge with reset released
        #1;
        chk(32'({pixel_transparent, overlay_irq, overlay_visible}), 32'h4);
        chk(32'(large_image_select), 32'h0);
        for (int a = 32'hc00; a <= 32'hc2c; a += 4) rc(12'(a), 32'h0);
        wr(`OVL_CONTROL_ADDR, 32'h21);
        rc(`OVL_CONTROL_ADDR, 32'h21);
        wr(`OVL_COLOUR_A_ADDR, 32'hff123456);
        rc(`OVL_COLOUR_A_ADDR, 32'h00123456);
        s_axi_wstrb <= 4'h2;
        wr(`OVL_COLOUR_A_ADDR, 32'h0000ab00);
        s_axi_wstrb <= 4'hf;
        rc(`OVL_COLOUR_A_ADDR, 32'h0012ab56);
        wr(`OVL_COLOUR_B_ADDR, 32'h00abcdef);
        wr(`OVL_POSITION_ADDR, 32'h03ff03ff);
        rc(`OVL_POSITION_ADDR, 32'h03ff03ff);
        wr(`OVL_TRIM_ADDR, 32'hffffffff);
        rc(`OVL_TRIM_ADDR, 32'h00003f3f);
        tick(2);
        chk(32'({overlay_visible, horizontal_origin, vertical_origin}), 32'h1fffff);
        chk(32'({horizontal_trim, vertical_trim}), 32'hfff);
        rc(12'he00, 32'h0);
        chk(32'(rs), 32'(`OVL_RESP_SLVERR));
        wr(12'he00, 32'h1);
        chk(32'(rs), 32'(`OVL_RESP_SLVERR));
        wr(`OVL_RAW_ADDR, 32'h1);
        chk(32'(rs), 32'(`OVL_RESP_OKAY));
        // every pixel code on a 24-bit panel, then the reduced panels
        for (int c = 0; c < 4; c++) begin
            @(posedge core_clk);
            scan_pixel_code <= 2'(c);
            tick(2);
            chk(32'({pixel_invert, pixel_transparent, pixel_colour}), exp_pix[c]);
        end
        @(posedge core_clk);
        panel_mode <= `OVL_PANEL_MONO_STN;
        scan_pixel_code <= 2'h0;
        tick(2);
        chk(32'(pixel_colour), 32'h000050);
        @(posedge core_clk);
        panel_mode <= `OVL_PANEL_COLOUR_STN;
        scan_pixel_code <= 2'h1;
        tick(2);
        chk(32'(pixel_colour), 32'ha0c0e0);
        // bitmap words tagged with their own index
        for (int i = 0; i < 5; i++)
            wr(`OVL_BITMAP_BASE + {2'h0, words[i], 2'h0}, {24'ha5c300, words[i]});
        rc(`OVL_BITMAP_LAST, 32'ha5c300ff);
        scan(8'h05);
        chk(scan_rd_data, 32'ha5c30085);
        scan(8'hc5);
        chk(scan_rd_data, 32'ha5c30085);
        wr(`OVL_CONFIG_ADDR, 32'h1);
        chk(32'(large_image_select), 32'h1);
        scan(8'h05);
        chk(scan_rd_data, 32'ha5c30005);
        // last word of the large image raises status; mask gates the output
        scan(8'd63);
        rc(`OVL_RAW_ADDR, 32'h0);
        scan(8'hff);
        rc(`OVL_RAW_ADDR, 32'h1);
        rc(`OVL_MASKED_ADDR, 32'h0);
        chk(32'(overlay_irq), 32'h0);
        wr(`OVL_MASK_ADDR, 32'h1);
        tick(1);
        chk(32'(overlay_irq), 32'h1);
        rc(`OVL_MASKED_ADDR, 32'h1);
        wr(`OVL_ACK_ADDR, 32'h0);
        rc(`OVL_RAW_ADDR, 32'h1);
        wr(`OVL_ACK_ADDR, 32'h1);
        tick(1);
        chk(32'(overlay_irq), 32'h0);
        rc(`OVL_RAW_ADDR, 32'h0);
        // blanking-synchronised updates: selection, then trim before position
        wr(`OVL_CONFIG_ADDR, 32'h2);
        wr(`OVL_CONTROL_ADDR, 32'h31);
        scan(8'h00);
        chk(scan_rd_data, 32'ha5c30080);
        wr(`OVL_TRIM_ADDR, 32'h0102);
        wr(`OVL_POSITION_ADDR, 32'h00050006);
        tick(2);
        chk(32'({vertical_origin, horizontal_origin}), 32'hfffff);
        chk(32'({vertical_trim, horizontal_trim}), 32'hfff);
        blank();
        chk(32'({vertical_origin, horizontal_origin}), 32'h1406);
        chk(32'({vertical_trim, horizontal_trim}), 32'h042);
        scan(8'h00);
        chk(scan_rd_data, 32'ha5c300c0);
        wr(`OVL_TRIM_ADDR, 32'h0304);
        blank();
        chk(32'({vertical_trim, horizontal_trim}), 32'h042);
        conclude();
    end
endmodule // test_hw_cursor_overlay_regs
`default_nettype wire
